// File: verilog/devctl_regs.v
/*
 * devctl_regs.v: device control register (low 18 bits), extended
 * control and status words, behind an AXI4-Lite slave.
 * Assumes one aclk at 100 MHz, synchronous active-low reset, PHY
 * indications arriving asynchronously, and a bus master engine that
 * reports outstanding requests on the same clock.
 */
`timescale 1ns/1ps
`include "devctl_defines.vh"

// Summary of operation
// R1: bit 0 selects duplex, reset 1, NVM-loadable
// R2: master disable blocks new bus master requests
// R3: master enable clears once disabled and nothing is pending
// R4: speed field 00/01/10 = 10/100/1000, reset 10
// R5: speed field ignored under automatic speed detection
// R6: software writes speed after reading PHY via MDIO
// R7: force speed takes MAC speed from field
// R8: speed bypass outranks force speed
// R9: software keeps PHY speed equal when forced
// R10: force duplex makes MAC follow bit 0
// R11: else sample PHY duplex on link rise
// R12: override bit gives software the power pin
// R13: overridden pin driven from bit 17
// R14: reserved bits read zero, bit 6 reads one
// R15: software writes reserved bit 7 as zero
// R16: control register also answers at 0x004
// R17: NVM values taken only with signature 01
// R18: writes land next edge, reads show fields
module devctl_regs (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // nvm load port, one-cycle strobe
    input  wire        nvm_load,
    input  wire [1:0]  nvm_signature,
    input  wire        nvm_duplex_full,
    input  wire        nvm_speed_override,
    // phy indications, asynchronous
    input  wire        phy_duplex_indication,
    input  wire        phy_link,
    input  wire [1:0]  phy_resolved_speed,
    // bus master engine, same clock
    input  wire        master_req,
    input  wire        master_pending,
    output wire        master_req_allowed,
    // internal power control and pin
    input  wire        phy_power_ctrl_int,
    output reg         phy_power_ctrl_pin,
    // resolved mac configuration
    output reg         mac_duplex_full,
    output reg  [1:0]  mac_speed
);
    // writable control fields
    reg       duplex_full_select_q;
    reg       master_disable_q;
    reg [1:0] speed_sel_q;
    reg       speed_override_enable_q;
    reg       duplex_override_enable_q;
    reg       pc_override_q;
    reg       pc_value_q;
    // extended control fields
    reg       speed_bypass_q;
    reg       auto_speed_q;
    // device state
    reg       master_enable_q;
    reg       phy_duplex_latched_q;
    reg       link_prev_q;
    // bus handshake state
    reg       aw_held_q;
    reg       w_held_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    wire       duplex_sync;
    wire       link_sync;
    wire [1:0] speed_sync;
    wire [31:0] ctrl_word;
    wire [31:0] ext_word;
    wire [31:0] status_word;
    wire       wr_go;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire       nvm_take;
    wire [31:0] ctrl_new;
    wire [31:0] ext_new;

    // phy inputs cross into aclk before any logic sees them
    devctl_sync #(.WIDTH(4)) devctl_sync_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({phy_resolved_speed, phy_link, phy_duplex_indication}),
        .dout    ({speed_sync, link_sync, duplex_sync})
    );

    // merge byte lanes of a write into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // control word, alias and primary share one decode
    function is_ctrl;
        input [11:0] a;
        begin
            is_ctrl = ({a[11:2], 2'b00} == `DEVCTL_OFS_CTRL) ||
                      ({a[11:2], 2'b00} == `DEVCTL_OFS_CTRL_ALIAS); // R16
        end
    endfunction

    // reserved bits fixed: all zero except bit 6
    assign ctrl_word = {14'h0000, pc_value_q, pc_override_q,
                        3'b000, duplex_override_enable_q,
                        speed_override_enable_q, 1'b0,
                        speed_sel_q, 1'b0, 1'b1, 3'b000,
                        master_disable_q, 1'b0,
                        duplex_full_select_q}; // R14
    assign ext_word = ({31'h0, speed_bypass_q} << `DEVCTL_EXT_BYPS_BIT) |
                      ({31'h0, auto_speed_q} << `DEVCTL_EXT_ASDE_BIT);
    assign status_word =
        ({31'h0, mac_duplex_full} << `DEVCTL_ST_DUPLEX_BIT) |
        ({31'h0, link_sync} << `DEVCTL_ST_LINK_BIT) |
        ({30'h0, mac_speed} << `DEVCTL_ST_SPD_LO) |
        ({31'h0, master_enable_q} << `DEVCTL_ST_MEN_BIT);

    // address and data may arrive in either order; hold each
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_go   = (aw_held_q || s_axi_awvalid) &&
                     (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    assign s_axi_arready = !s_axi_rvalid;
    assign nvm_take = nvm_load &&
                      (nvm_signature == `DEVCTL_NVM_SIG_OK); // R17

    // candidate words once a write's byte lanes land on them
    assign ctrl_new = merge(ctrl_word, wr_data, wr_strb);
    assign ext_new  = merge(ext_word, wr_data, wr_strb);

    // write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DEVCTL_RESP_OKAY;
        end else if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (is_ctrl(wr_addr) ||
                             wr_addr[11:2] == `DEVCTL_OFS_EXT >> 2 ||
                             wr_addr[11:2] == `DEVCTL_OFS_STATUS >> 2) ?
                            `DEVCTL_RESP_OKAY : `DEVCTL_RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control fields: nvm load, then software writes on top
    always @(posedge aclk) begin
        if (!aresetn) begin
            duplex_full_select_q     <= `DEVCTL_RST_DUPSEL; // R1
            master_disable_q         <= 1'b0;
            speed_sel_q              <= `DEVCTL_RST_SPD; // R4
            speed_override_enable_q  <= `DEVCTL_RST_SPDOVR; // R7
            duplex_override_enable_q <= 1'b0;
            pc_override_q            <= 1'b0; // R12
            pc_value_q               <= 1'b0;
            speed_bypass_q           <= 1'b0;
            auto_speed_q             <= 1'b0;
        end else begin
            if (nvm_take) begin
                duplex_full_select_q    <= nvm_duplex_full; // R1
                speed_override_enable_q <= nvm_speed_override; // R7
            end
            if (wr_go && is_ctrl(wr_addr)) begin
                duplex_full_select_q     <= ctrl_new[`DEVCTL_DUPSEL_BIT]; // R18
                master_disable_q         <= ctrl_new[`DEVCTL_MDIS_BIT];
                speed_sel_q <= ctrl_new[`DEVCTL_SPD_HI:`DEVCTL_SPD_LO];
                speed_override_enable_q  <= ctrl_new[`DEVCTL_SPDOVR_BIT];
                duplex_override_enable_q <= ctrl_new[`DEVCTL_DPXOVR_BIT];
                pc_override_q            <= ctrl_new[`DEVCTL_PCOVR_BIT];
                pc_value_q               <= ctrl_new[`DEVCTL_PCVAL_BIT];
            end
            if (wr_go && wr_addr[11:2] == `DEVCTL_OFS_EXT >> 2) begin
                speed_bypass_q <= ext_new[`DEVCTL_EXT_BYPS_BIT];
                auto_speed_q   <= ext_new[`DEVCTL_EXT_ASDE_BIT];
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `DEVCTL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `DEVCTL_RESP_OKAY;
            if (is_ctrl(s_axi_araddr)) begin
                s_axi_rdata <= ctrl_word; // R18
            end else if (s_axi_araddr[11:2] == `DEVCTL_OFS_EXT >> 2) begin
                s_axi_rdata <= ext_word;
            end else if (s_axi_araddr[11:2] ==
                         `DEVCTL_OFS_STATUS >> 2) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `DEVCTL_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // gate new requests; in-flight ones finish on their own
    assign master_req_allowed = master_req && !master_disable_q; // R2

    // master enable status drops once disabled and drained
    always @(posedge aclk) begin
        if (!aresetn) begin
            master_enable_q <= 1'b1;
        end else if (master_disable_q && !master_pending) begin
            master_enable_q <= 1'b0; // R3
        end else if (!master_disable_q) begin
            master_enable_q <= 1'b1;
        end
    end

    // duplex follows phy only at link rising edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_prev_q          <= 1'b0;
            phy_duplex_latched_q <= 1'b0;
        end else begin
            link_prev_q <= link_sync;
            if (link_sync && !link_prev_q) begin
                phy_duplex_latched_q <= duplex_sync; // R11
            end
        end
    end

    // resolved mac settings and power pin, all registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            mac_duplex_full    <= 1'b0;
            mac_speed          <= `DEVCTL_RST_SPD;
            phy_power_ctrl_pin <= 1'b0;
        end else begin
            if (duplex_override_enable_q) begin
                mac_duplex_full <= duplex_full_select_q; // R10
            end else begin
                mac_duplex_full <= phy_duplex_latched_q; // R11
            end
            // bypass first: it outranks force speed
            if (speed_bypass_q) begin
                mac_speed <= speed_sync; // R8
            end else if (speed_override_enable_q && !auto_speed_q) begin
                mac_speed <= speed_sel_q; // R7
            end else begin
                mac_speed <= speed_sync; // R5
            end
            if (pc_override_q) begin
                phy_power_ctrl_pin <= pc_value_q; // R13
            end else begin
                phy_power_ctrl_pin <= phy_power_ctrl_int; // R12
            end
        end
    end
endmodule

// File: verilog/devctl_defines.vh
/*
 * devctl_defines.vh: offsets, field positions, reset values, NVM
 * signature and response codes for the device control register bank.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DEVCTL_DEFINES_VH
`define DEVCTL_DEFINES_VH

// register byte addresses
`define DEVCTL_OFS_CTRL        12'h000
`define DEVCTL_OFS_CTRL_ALIAS  12'h004
`define DEVCTL_OFS_EXT         12'h018
`define DEVCTL_OFS_STATUS      12'h008

// control register field positions
`define DEVCTL_DUPSEL_BIT      0
`define DEVCTL_MDIS_BIT        2
`define DEVCTL_RSV6_BIT        6
`define DEVCTL_SPD_LO          8
`define DEVCTL_SPD_HI          9
`define DEVCTL_SPDOVR_BIT      11
`define DEVCTL_DPXOVR_BIT      12
`define DEVCTL_PCOVR_BIT       16
`define DEVCTL_PCVAL_BIT       17

// extended control register field positions
`define DEVCTL_EXT_BYPS_BIT    15
`define DEVCTL_EXT_ASDE_BIT    12

// status register field positions
`define DEVCTL_ST_DUPLEX_BIT   0
`define DEVCTL_ST_LINK_BIT     1
`define DEVCTL_ST_SPD_LO       6
`define DEVCTL_ST_SPD_HI       7
`define DEVCTL_ST_MEN_BIT      19

// reset values and nvm signature
`define DEVCTL_RST_DUPSEL      1'b1
`define DEVCTL_RST_SPD         2'b10
`define DEVCTL_RST_SPDOVR      1'b0
`define DEVCTL_NVM_SIG_OK      2'b01

// axi response codes
`define DEVCTL_RESP_OKAY       2'b00
`define DEVCTL_RESP_SLVERR     2'b10

`endif

// File: verilog/devctl_sync.v
/*
 * devctl_sync.v: two flip-flop level synchroniser, one per bit.
 * Assumes inputs come from outside the aclk domain.
 */
`timescale 1ns/1ps
module devctl_sync #(
    parameter WIDTH = 1
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// File: bench/devctl_regs_props.sv
/* devctl_regs_props.sv: assertions on the control register ports.
   Assumes binding to devctl_regs and a master that offers write
   address and data together with all byte strobes set. */
`timescale 1ns/1ps
`include "devctl_defines.vh"
module devctl_regs_props (
    input wire        aclk,
    input wire        aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        master_req,
    input wire        master_req_allowed,
    input wire        phy_power_ctrl_int,
    input wire        phy_power_ctrl_pin
);
    reg  ovr_q;
    reg  val_q;
    reg  mdis_q;
    wire wr_ctl;
    wire aw_w_hs;

    // shadow of the bits that steer the pin and the request gate
    assign aw_w_hs = s_axi_awvalid && s_axi_awready
                  && s_axi_wvalid && s_axi_wready;
    assign wr_ctl = aw_w_hs && (s_axi_awaddr == `DEVCTL_OFS_CTRL
                  || s_axi_awaddr == `DEVCTL_OFS_CTRL_ALIAS);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ovr_q  <= 1'b0;
            val_q  <= 1'b0;
            mdis_q <= 1'b0;
        end else if (wr_ctl) begin
            ovr_q  <= s_axi_wdata[16];
            val_q  <= s_axi_wdata[17];
            mdis_q <= s_axi_wdata[2];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_req_gate;
        master_req_allowed == (master_req && !mdis_q);
    endproperty
    property p_pin_ovr;
        ovr_q && $past(ovr_q) |-> phy_power_ctrl_pin == $past(val_q);
    endproperty
    // past reset guard: pin is still at its reset level on release
    property p_pin_int;
        $past(aresetn) && !ovr_q && !$past(ovr_q)
            |-> phy_power_ctrl_pin == $past(phy_power_ctrl_int);
    endproperty
    property p_aw_answer;
        aw_w_hs |=> s_axi_bvalid;
    endproperty
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty

    a_req_gate: assert property (p_req_gate)
        else $error("request gate wrong");
    a_pin_ovr: assert property (p_pin_ovr)
        else $error("overridden pin wrong");
    a_pin_int: assert property (p_pin_int)
        else $error("pin not from internal logic");
    a_aw_answer: assert property (p_aw_answer)
        else $error("no write response");
    a_ar_answer: assert property (p_ar_answer)
        else $error("no read data");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    a_ar_refuse: assert property (p_ar_refuse)
        else $error("read taken while busy");

    c_wr_ctl: cover property (wr_ctl);
    c_r_done: cover property (s_axi_rvalid && s_axi_rready);
    c_ovr_pin: cover property (ovr_q && phy_power_ctrl_pin);
endmodule

bind devctl_regs devctl_regs_props devctl_regs_props_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .master_req, .master_req_allowed,
    .phy_power_ctrl_int, .phy_power_ctrl_pin);

// File: bench/devctl_regs_tb.sv
/* devctl_regs_tb.sv: self-checking bench for the control register.
   Assumes devctl_regs and its bound checker; bus master is here. */
`timescale 1ns/1ps
`include "devctl_defines.vh"
module devctl_regs_tb;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [11:0] s_axi_awaddr = 12'h000;
    reg         s_axi_awvalid = 1'b0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hf;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg  [11:0] s_axi_araddr = 12'h000;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    reg         nvm_load = 1'b0;
    reg  [1:0]  nvm_signature = 2'b00;
    reg         nvm_duplex_full = 1'b0;
    reg         nvm_speed_override = 1'b0;
    reg         phy_duplex_indication = 1'b0;
    reg         phy_link = 1'b0;
    reg  [1:0]  phy_resolved_speed = 2'b01;
    reg         master_req = 1'b0;
    reg         master_pending = 1'b0;
    reg         phy_power_ctrl_int = 1'b0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, master_req_allowed, phy_power_ctrl_pin;
    wire        mac_duplex_full;
    wire [1:0]  s_axi_bresp, s_axi_rresp, mac_speed;
    wire [31:0] s_axi_rdata;
    reg  [1:0]  resp;
    reg  [31:0] rd;
    integer     n_fail = 0;
    integer     total_checks = 0;
    integer     i;

    devctl_regs devctl_regs_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .nvm_load, .nvm_signature, .nvm_duplex_full, .nvm_speed_override,
        .phy_duplex_indication, .phy_link, .phy_resolved_speed,
        .master_req, .master_pending, .master_req_allowed,
        .phy_power_ctrl_int, .phy_power_ctrl_pin, .mac_duplex_full,
        .mac_speed);

    always #5 aclk = ~aclk;

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected %s: expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // response ready offered with the request and held until answered
    task wr(input [11:0] a, input [31:0] d);
        reg got;
        begin
            got = 1'b0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!got) begin
                @(posedge aclk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid && s_axi_bready) begin
                    got = 1'b1;
                    resp = s_axi_bresp;
                end
            end
            s_axi_bready <= 1'b0;
        end
    endtask

    task rdt(input [11:0] a);
        reg got;
        begin
            got = 1'b0;
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!got) begin
                @(posedge aclk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid && s_axi_rready) begin
                    got = 1'b1;
                    resp = s_axi_rresp;
                    rd = s_axi_rdata;
                end
            end
            s_axi_rready <= 1'b0;
        end
    endtask

    task rchk(input [11:0] a, input [31:0] exp, input string nm);
        begin
            rdt(a);
            chk(nm, rd, exp);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // run needs well under 2000 cycles
    initial begin
        #50000;
        n_fail = n_fail + 1;
        $display("watchdog expired");
        wrap_up;
    end

    initial begin
        cyc(2);
        aresetn <= 1'b1;
        rchk(`DEVCTL_OFS_CTRL, 32'h241, "ctrl reset");
        $display("test reset done");
        // requests outstanding before disable, so status must wait
        master_req <= 1'b1;
        master_pending <= 1'b1;
        // all writable bits set; bit 7 kept clear as software must
        wr(`DEVCTL_OFS_CTRL, 32'hffffff7f);
        chk("wr resp", resp, 2'b00);
        rchk(`DEVCTL_OFS_CTRL, 32'h31b45, "ctrl fields");
        rchk(`DEVCTL_OFS_CTRL_ALIAS, 32'h31b45, "alias");
        chk("pin ovr 1", phy_power_ctrl_pin, 1'b1);
        cyc(2);
        chk("req gated", master_req_allowed, 1'b0);
        rchk(`DEVCTL_OFS_STATUS, 32'h800c1, "men held");
        master_pending <= 1'b0;
        rdt(`DEVCTL_OFS_STATUS);
        chk("men clear", rd[19], 1'b0);
        $display("test master disable done");
        wr(`DEVCTL_OFS_CTRL_ALIAS, 32'h10000);
        chk("req open", master_req_allowed, 1'b1);
        phy_power_ctrl_int <= 1'b1;
        cyc(3);
        chk("pin ovr 0", phy_power_ctrl_pin, 1'b0);
        wr(`DEVCTL_OFS_CTRL, 32'h0);
        cyc(3);
        chk("pin int 1", phy_power_ctrl_pin, 1'b1);
        phy_power_ctrl_int <= 1'b0;
        cyc(3);
        chk("pin int 0", phy_power_ctrl_pin, 1'b0);
        $display("test power pin done");
        // phy state read back before the speed field is written
        rchk(`DEVCTL_OFS_STATUS, 32'h80040, "phy status");
        for (i = 0; i < 3; i = i + 1) begin
            wr(`DEVCTL_OFS_CTRL, 32'h800 | (i << 8));
            cyc(3);
            chk("forced speed", mac_speed, i);
        end
        phy_resolved_speed <= 2'b10;
        cyc(3);
        chk("forced match", mac_speed, 2'b10);
        phy_resolved_speed <= 2'b01;
        wr(`DEVCTL_OFS_EXT, 32'h1000);
        cyc(3);
        chk("auto speed", mac_speed, 2'b01);
        wr(`DEVCTL_OFS_EXT, 32'h8000);
        cyc(3);
        chk("bypass speed", mac_speed, 2'b01);
        $display("test speed done");
        wr(`DEVCTL_OFS_CTRL, 32'h1001);
        cyc(3);
        chk("forced duplex 1", mac_duplex_full, 1'b1);
        wr(`DEVCTL_OFS_CTRL, 32'h1000);
        cyc(3);
        chk("forced duplex 0", mac_duplex_full, 1'b0);
        wr(`DEVCTL_OFS_CTRL, 32'h0);
        phy_duplex_indication <= 1'b1;
        cyc(3);
        phy_link <= 1'b1;
        cyc(8);
        chk("link duplex", mac_duplex_full, 1'b1);
        phy_duplex_indication <= 1'b0;
        cyc(8);
        chk("duplex held", mac_duplex_full, 1'b1);
        $display("test duplex done");
        nvm_signature <= 2'b10;
        nvm_duplex_full <= 1'b1;
        nvm_speed_override <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            nvm_load <= 1'b1;
            cyc(1);
            nvm_load <= 1'b0;
            rchk(`DEVCTL_OFS_CTRL, i ? 32'h841 : 32'h40, "nvm");
            nvm_signature <= 2'b01;
        end
        $display("test nvm done");
        rchk(12'h100, 32'h0, "unmapped data");
        chk("unmapped resp", resp, 2'b10);
        wr(12'h100, 32'h1);
        chk("unmapped wr", resp, 2'b10);
        $display("test unmapped done");
        wrap_up;
    end
endmodule
